// ### bench/scan_host.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// scan host model: tck parked low between bits, 160 ns per bit
module scan_host (
  // bench clock used only for timing
  input wire logic clk_sys_in,
  // test port pins
  output logic tck_out,
  output logic tms_out,
  output logic trst_b_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    trst_b_out = 1'b1;
  end
  // tms moves only in the low phase so it is settled long before the rise
  task automatic bit_step(input logic t);
    @(negedge clk_sys_in);
    tms_out = t;
    repeat (19) @(negedge clk_sys_in);
    tck_out = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    tck_out = 1'b0;
  endtask
  // trst low with a tck bit inside it, which must be ignored
  task automatic trst_pulse();
    @(negedge clk_sys_in);
    trst_b_out = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    bit_step(1'b0);
    trst_b_out = 1'b1;
    repeat (8) @(negedge clk_sys_in);
  endtask
endmodule // scan_host
`default_nettype wire

// ### bench/tap_fsm_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// port-level checks of the test port controller
module tap_fsm_properties
  import tap_pkg::*;
(
  // clock, reset and host pins
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic trst_b_in,
  // controller outputs
  input wire logic [TAP_STATE_COUNT-1:0] tap_state_out,
  input wire logic select_ir_out,
  input wire logic dr_active_out,
  input wire logic dr_clock_out,
  input wire logic tck_rise_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // cycles of trst high, saturating; the sync lag makes early cycles unsafe
  logic [2:0] trst_hi;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) trst_hi <= 3'h0;
    else if (!trst_b_in) trst_hi <= 3'h0;
    else if (trst_hi != 3'h7) trst_hi <= trst_hi + 3'h1;
  end
  property p_onehot; $onehot(tap_state_out); endproperty
  a_onehot: assert property (p_onehot) else $error("state not one-hot");
  property p_hold; $changed(tap_state_out) && trst_hi == 3'h7 |-> tck_rise_out; endproperty
  a_hold: assert property (p_hold) else $error("state moved without tck rise");
  property p_rise_pulse; tck_rise_out |=> !tck_rise_out; endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("rise strobe too long");
  property p_rise_lat; $rose(tck_in) && trst_hi == 3'h7 |-> ##[1:5] tck_rise_out; endproperty
  a_rise_lat: assert property (p_rise_lat) else $error("tck rise not taken");
  property p_trst; !trst_b_in [*4] |-> tap_state_out == TAP_RESET; endproperty
  a_trst: assert property (p_trst) else $error("trst did not reset");
  property p_ir_flag; select_ir_out == |(tap_state_out & IR_STATE_MASK); endproperty
  a_ir_flag: assert property (p_ir_flag) else $error("ir select level wrong");
  property p_dr_flag; dr_active_out == |(tap_state_out & DR_STATE_MASK); endproperty
  a_dr_flag: assert property (p_dr_flag) else $error("dr active level wrong");
  property p_shift_clk; tck_rise_out && $past(tap_state_out) == TAP_DR_SHIFT |-> dr_clock_out;
  endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("no dr clock in shift");
  c_dr_clock: cover property (dr_clock_out);
  c_ir_rise: cover property (select_ir_out && tck_rise_out);
  c_trst: cover property (!trst_b_in ##1 trst_b_in);
endmodule // tap_fsm_properties
`default_nettype wire

// ### bench/tb_tap_controller_fsm.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// bench top
module tb_tap_controller_fsm;
  import tap_pkg::*;
  logic clk_sys_in, rst_b_in, tck, tms, trst_b;
  logic [15:0] st;
  logic test_reset, sel_ir, dr_act, sh;
  logic ir_act, cap, upd;
  wire [5:0] pulse;
  logic [7:0] pcnt [6];
  int err_count = 0;
  int tests_run = 0;
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  scan_host u_host (.clk_sys_in(clk_sys_in), .tck_out(tck), .tms_out(tms), .trst_b_out(trst_b));
  tap_controller_fsm DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tck_in(tck),
    .tms_in(tms), .trst_b_in(trst_b), .tap_state_out(st), .test_reset_out(test_reset),
    .select_ir_out(sel_ir), .ir_active_out(ir_act), .dr_active_out(dr_act),
    .capture_en_out(cap), .shift_en_out(sh), .update_en_out(upd), .ir_clock_out(pulse[5]),
    .dr_clock_out(pulse[4]), .ir_update_out(pulse[3]), .dr_update_out(pulse[2]),
    .tck_rise_out(pulse[1]), .tck_fall_out(pulse[0]));
  // strobe counters: ir clock, dr clock, ir update, dr update, tck rise, tck fall
  always_ff @(posedge clk_sys_in) begin
    for (int k = 0; k < 6; k++) pcnt[k] <= rst_b_in ? pcnt[k] + {7'h0, pulse[k]} : 8'h00;
  end
  task automatic final_report();
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bit, then state and the levels that follow from it
  task automatic step(input logic t, input logic [15:0] e);
    u_host.bit_step(t);
    chk("state", e, st);
    chk("levels", {9'h0, e[0], |(e & IR_STATE_MASK), |(e & IR_STATE_MASK),
      |(e & DR_STATE_MASK), e[3] | e[10], e[4] | e[11], e[8] | e[15]},
      {9'h0, test_reset, sel_ir, ir_act, dr_act, cap, sh, upd});
  endtask
  // strobes counted since base, after the last fall has had time to arrive
  task automatic pulses(input logic [7:0] base [6], input logic [47:0] e);
    repeat (8) @(negedge clk_sys_in);
    for (int k = 0; k < 6; k++)
      chk("strobe count", {8'h00, e[8*k +: 8]}, {8'h00, pcnt[k] - base[k]});
  endtask
  // bits are taken msb first, one per listed state
  task automatic walk(input logic [15:0] b, input tap_state_t s [$]);
    for (int i = 0; i < s.size(); i++) step(b[s.size() - 1 - i], s[i]);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_dr_walk();
    walk(16'h0896, '{TAP_IDLE, TAP_IDLE, TAP_DR_SELECT, TAP_DR_CAPTURE, TAP_DR_SHIFT,
      TAP_DR_SHIFT, TAP_DR_EXIT1, TAP_DR_PAUSE, TAP_DR_PAUSE, TAP_DR_EXIT2, TAP_DR_SHIFT,
      TAP_DR_EXIT1, TAP_DR_UPDATE, TAP_IDLE});
  endtask
  task automatic t_ir_walk();
    walk(16'h0196, '{TAP_DR_SELECT, TAP_IR_SELECT, TAP_IR_CAPTURE, TAP_IR_SHIFT, TAP_IR_EXIT1,
      TAP_IR_PAUSE, TAP_IR_EXIT2, TAP_IR_UPDATE, TAP_IDLE});
  endtask
  // strobe counts over one dr pass and one ir pass, idle to idle
  task automatic t_strobes();
    logic [7:0] b [6];
    repeat (8) @(negedge clk_sys_in);
    b = pcnt;
    walk(16'h0046, '{TAP_DR_SELECT, TAP_DR_CAPTURE, TAP_DR_SHIFT, TAP_DR_SHIFT, TAP_DR_EXIT1,
      TAP_DR_UPDATE, TAP_IDLE});
    pulses(b, 48'h00_03_00_01_07_07);
    b = pcnt;
    walk(16'h0066, '{TAP_DR_SELECT, TAP_IR_SELECT, TAP_IR_CAPTURE, TAP_IR_SHIFT, TAP_IR_EXIT1,
      TAP_IR_UPDATE, TAP_IDLE});
    pulses(b, 48'h02_00_01_00_07_07);
  endtask
  // four ones from shift must not yet reach reset, the fifth must
  task automatic t_five_ones();
    walk(16'h033F, '{TAP_DR_SELECT, TAP_IR_SELECT, TAP_IR_CAPTURE, TAP_IR_SHIFT, TAP_IR_EXIT1,
      TAP_IR_UPDATE, TAP_DR_SELECT, TAP_IR_SELECT, TAP_RESET, TAP_RESET});
  endtask
  task automatic t_trst();
    walk(16'h0004, '{TAP_IDLE, TAP_DR_SELECT, TAP_DR_CAPTURE, TAP_DR_SHIFT});
    u_host.trst_pulse();
    chk("trst state", TAP_RESET, st);
    step(1'b0, TAP_IDLE);
  endtask
  task automatic t_rst_mid();
    step(1'b1, TAP_DR_SELECT);
    @(negedge clk_sys_in);
    rst_b_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk("reset state", TAP_RESET, st);
    rst_b_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    step(1'b0, TAP_IDLE);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    rst_b_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk("power-up state", TAP_RESET, st);
    rst_b_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    t_dr_walk();
    t_ir_walk();
    t_strobes();
    t_five_ones();
    t_trst();
    t_rst_mid();
    final_report();
  end
endmodule // tb_tap_controller_fsm
bind tap_controller_fsm tap_fsm_properties u_props (.clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in), .tck_in(tck_in), .trst_b_in(trst_b_in), .tap_state_out(tap_state_out),
  .select_ir_out(select_ir_out), .dr_active_out(dr_active_out), .dr_clock_out(dr_clock_out),
  .tck_rise_out(tck_rise_out));
`default_nettype wire

// ### src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// pin synchroniser: two flops per bit plus one history flop for edge finding
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // asynchronous pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised level and its value one cycle before
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] prev_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // stage1 feeds stage2 only; edges are found between stage2 and stage3
  always_comb begin
    next_s = s;
    next_s.stage1 = pin_in;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= {RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.stage2;
  assign prev_out = s.stage3;

endmodule // pin_sync
`default_nettype wire

// ### src/tap_controller_fsm.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) sixteen-state test port controller machine
// (R2) every transition uses tms at tck rise
// (R3) instruction register works in ir states
// (R4) selected data register works in dr states
// (R5) only tms, tck steer; emits test strobes
// (R6) power-up or trst forces test-logic-reset
// (R7) five tck rises with tms high resets
// (R8) standard graph; idle and pauses hold
module tap_controller_fsm
  import tap_pkg::*;
(
  // system clock and power-up reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // test port pins from the scan host
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic trst_b_in,
  // controller state
  output logic [TAP_STATE_COUNT-1:0] tap_state_out,
  output logic test_reset_out,
  output logic select_ir_out,
  // register operation levels for the test logic
  output logic ir_active_out,
  output logic dr_active_out,
  output logic capture_en_out,
  output logic shift_en_out,
  output logic update_en_out,
  // one-cycle strobes standing in for the test clock
  output logic ir_clock_out,
  output logic dr_clock_out,
  output logic ir_update_out,
  output logic dr_update_out,
  output logic tck_rise_out,
  output logic tck_fall_out
);

  // ==========================================================================
  // pin synchronisers
  logic [2:0] pin_level;
  logic [2:0] pin_prev;

  // pins gathered in one word, trst on top, tck at the bottom
  logic [2:0] pin_raw;
  assign pin_raw = {trst_b_in, tms_in, tck_in};

  // tck, tms and trst travel the same depth so tms lines up with the tck edge
  pin_sync #(
    .WIDTH(3),
    .RESET_VAL({PIN_TRST_B_RESET, PIN_TMS_RESET, PIN_TCK_RESET})
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .pin_in(pin_raw),
    .level_out(pin_level),
    .prev_out(pin_prev)
  );

  logic tck_rise;
  logic tck_fall;
  logic tms_now;
  logic trst_active;

  // edges are seen from stage two against stage three, never from stage one;
  // each tck phase must last one clock or more or its edge can be lost
  assign tck_rise = pin_level[0] & ~pin_prev[0];
  assign tck_fall = ~pin_level[0] & pin_prev[0];
  assign tms_now = pin_level[1];
  assign trst_active = ~pin_level[2];

  // a tck edge counts only while trst is released, so trst wins a tie
  logic step_ok;
  logic fall_ok;
  assign step_ok = tck_rise & ~trst_active;
  assign fall_ok = tck_fall & ~trst_active;

  // ==========================================================================
  // transition graph
  function automatic tap_state_t tap_next(input tap_state_t cur, input logic tms);
    tap_state_t nxt;
    nxt = TAP_RESET;
    // left column is data, right column is instruction; tms high walks
    // toward select and reset, tms low toward shift, pause and idle, so a
    // host that parks tms low brings the machine to rest in idle, a shift or a pause
    unique case (cur)
      TAP_RESET:      nxt = tms ? TAP_RESET : TAP_IDLE;         // [R7]
      TAP_IDLE:       nxt = tms ? TAP_DR_SELECT : TAP_IDLE;     // [R8]
      TAP_DR_SELECT:  nxt = tms ? TAP_IR_SELECT : TAP_DR_CAPTURE;
      TAP_DR_CAPTURE: nxt = tms ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
      TAP_DR_SHIFT:   nxt = tms ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
      TAP_DR_EXIT1:   nxt = tms ? TAP_DR_UPDATE : TAP_DR_PAUSE;
      TAP_DR_PAUSE:   nxt = tms ? TAP_DR_EXIT2 : TAP_DR_PAUSE;  // [R8]
      TAP_DR_EXIT2:   nxt = tms ? TAP_DR_UPDATE : TAP_DR_SHIFT;
      TAP_DR_UPDATE:  nxt = tms ? TAP_DR_SELECT : TAP_IDLE;
      TAP_IR_SELECT:  nxt = tms ? TAP_RESET : TAP_IR_CAPTURE;   // [R7]
      TAP_IR_CAPTURE: nxt = tms ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
      TAP_IR_SHIFT:   nxt = tms ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
      TAP_IR_EXIT1:   nxt = tms ? TAP_IR_UPDATE : TAP_IR_PAUSE;
      TAP_IR_PAUSE:   nxt = tms ? TAP_IR_EXIT2 : TAP_IR_PAUSE;  // [R8]
      TAP_IR_EXIT2:   nxt = tms ? TAP_IR_UPDATE : TAP_IR_SHIFT;
      TAP_IR_UPDATE:  nxt = tms ? TAP_DR_SELECT : TAP_IDLE;
      // an upset code falls back to the safe reset state
      default:        nxt = TAP_RESET;
    endcase
    return nxt;
  endfunction

  // ==========================================================================
  // state class decoding, shared by levels and strobes
  // instruction column: select through update
  function automatic logic in_ir_column(input tap_state_t st);
    return |(st & IR_STATE_MASK);
  endfunction

  // data column: select through update
  function automatic logic in_dr_column(input tap_state_t st);
    return |(st & DR_STATE_MASK);
  endfunction

  // capture state of either column
  function automatic logic is_capture(input tap_state_t st);
    return st inside {TAP_IR_CAPTURE, TAP_DR_CAPTURE};
  endfunction

  // shift state of either column
  function automatic logic is_shift(input tap_state_t st);
    return st inside {TAP_IR_SHIFT, TAP_DR_SHIFT};
  endfunction

  // update state of either column
  function automatic logic is_update(input tap_state_t st);
    return st inside {TAP_IR_UPDATE, TAP_DR_UPDATE};
  endfunction

  // register clock sources: capture or shift of the chosen column
  function automatic logic clocks_column(input tap_state_t st, input logic ir_col);
    return (is_capture(st) | is_shift(st)) & (ir_col ? in_ir_column(st) : in_dr_column(st));
  endfunction

  // ==========================================================================
  // machine state and registered outputs
  typedef struct packed {
    // controller state
    tap_state_t state;
    // registered levels
    logic test_reset;
    logic select_ir;
    logic ir_active;
    logic dr_active;
    logic capture_en;
    logic shift_en;
    logic update_en;
    // one-cycle strobes
    logic ir_clock;
    logic dr_clock;
    logic ir_update;
    logic dr_update;
    logic tck_rise;
    logic tck_fall;
  } tap_regs_t;

  tap_regs_t s;
  tap_regs_t next_s;

  // next state: trst overrides, otherwise step only on a tck rise
  always_comb begin
    next_s = s;
    if (trst_active) begin
      next_s.state = TAP_RESET;                                 // [R6]
    end else if (tck_rise) begin
      next_s.state = tap_next(s.state, tms_now);                // [R1] [R2] [R5]
    end
    // strobes: registers clock on the rise that leaves capture or shift
    next_s.tck_rise = step_ok;                                  // [R5]
    next_s.tck_fall = fall_ok;                                  // [R5]
    next_s.ir_clock = step_ok & clocks_column(s.state, 1'b1);   // [R3]
    next_s.dr_clock = step_ok & clocks_column(s.state, 1'b0);   // [R4]
    // update latches on the falling tck while sitting in an update state
    next_s.ir_update = fall_ok & (s.state == TAP_IR_UPDATE);    // [R3]
    next_s.dr_update = fall_ok & (s.state == TAP_DR_UPDATE);    // [R4]
    // levels follow the new state so they line up with tap_state_out
    next_s.test_reset = (next_s.state == TAP_RESET);           // [R6]
    next_s.ir_active = in_ir_column(next_s.state);              // [R3]
    next_s.dr_active = in_dr_column(next_s.state);              // [R4]
    next_s.select_ir = in_ir_column(next_s.state);
    // phase levels are shared by both columns
    next_s.capture_en = is_capture(next_s.state);
    next_s.shift_en = is_shift(next_s.state);
    next_s.update_en = is_update(next_s.state);
  end

  // power-up reset lands in test-logic-reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '{state: TAP_RESET, test_reset: 1'b1, default: 1'b0};  // [R6]
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs straight from the state flops; levels are copies of the new
  // state, so they never glitch between tck edges, at the price of one
  // clock of latency after the synchroniser
  assign tap_state_out = s.state;
  assign test_reset_out = s.test_reset;
  assign select_ir_out = s.select_ir;
  assign ir_active_out = s.ir_active;
  assign dr_active_out = s.dr_active;
  assign capture_en_out = s.capture_en;
  assign shift_en_out = s.shift_en;
  assign update_en_out = s.update_en;
  assign ir_clock_out = s.ir_clock;
  assign dr_clock_out = s.dr_clock;
  assign ir_update_out = s.ir_update;
  assign dr_update_out = s.dr_update;
  assign tck_rise_out = s.tck_rise;
  assign tck_fall_out = s.tck_fall;

endmodule // tap_controller_fsm
`default_nettype wire

// ### src/tap_pkg.sv
`default_nettype none
package tap_pkg;

  // ==========================================================================
  // sizes
  localparam int TAP_STATE_COUNT = 16;
  localparam int SYNC_DEPTH = 2;

  // ==========================================================================
  // controller states, one-hot
  typedef enum logic [TAP_STATE_COUNT-1:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_DR_SELECT  = 16'h0004,
    TAP_DR_CAPTURE = 16'h0008,
    TAP_DR_SHIFT   = 16'h0010,
    TAP_DR_EXIT1   = 16'h0020,
    TAP_DR_PAUSE   = 16'h0040,
    TAP_DR_EXIT2   = 16'h0080,
    TAP_DR_UPDATE  = 16'h0100,
    TAP_IR_SELECT  = 16'h0200,
    TAP_IR_CAPTURE = 16'h0400,
    TAP_IR_SHIFT   = 16'h0800,
    TAP_IR_EXIT1   = 16'h1000,
    TAP_IR_PAUSE   = 16'h2000,
    TAP_IR_EXIT2   = 16'h4000,
    TAP_IR_UPDATE  = 16'h8000
  } tap_state_t;

  // ==========================================================================
  // mask of states that work on the instruction register
  localparam logic [TAP_STATE_COUNT-1:0] IR_STATE_MASK = 16'hFE00;
  // mask of states that work on the selected data register
  localparam logic [TAP_STATE_COUNT-1:0] DR_STATE_MASK = 16'h01FC;

  // ==========================================================================
  // reset levels of the synchronised pins: tck low, tms high, trst asserted
  localparam logic PIN_TCK_RESET = 1'b0;
  localparam logic PIN_TMS_RESET = 1'b1;
  localparam logic PIN_TRST_B_RESET = 1'b0;

endpackage
`default_nettype wire
